// ==== design/sigstk_pkg.sv ====
// Purpose: Shared constants for the signaling change queue and slip phase status block
// Assumes: Byte-wide register port, one framer per instance
// Notes: Offsets are byte addresses on the framer register port
package sigstk_pkg;
  localparam logic [7:0] ADDR_SIG_QUEUE = 8'hDA;
  localparam logic [7:0] ADDR_RX_PHASE = 8'hDB;
  localparam logic [7:0] ADDR_TX_PHASE = 8'hDC;
  localparam int NUM_CHANNELS = 32;
  localparam int QUEUE_DEPTH = 32;
  localparam int CH_W = 5;
  localparam int PTR_W = 5;
  localparam int WORD_ID_BIT = 7;
  localparam int MORE_BIT = 6;
  localparam int DELAY_LSB = 2;
  localparam int DELAY_W = 6;
  localparam int HALF_WR_BIT = 1;
  localparam int HALF_RD_BIT = 0;
  localparam int DELAY_STEP_BITS = 8;
  localparam int DELAY_SHIFT = 3;
  localparam logic [7:0] PHASE_RESET = 8'h00;
  localparam logic [7:0] QUEUE_EMPTY_WORD = 8'h80;
endpackage

// ==== design/sigstk_push_if.sv ====
// Purpose: Carries one candidate queue entry from the channel scanner to the queue
// Assumes: Single clock domain
// Notes: valid is a one-cycle pulse per evaluation of a queue-enabled channel that found a change
`timescale 1ns/1ps
interface sigstk_push_if;
  logic valid;
  logic [4:0] channel;
  logic [3:0] abcd;
  logic full;
  modport src (output valid, output channel, output abcd, input full);
  modport dst (input valid, input channel, input abcd, output full);
endinterface

// ==== design/sigstk_scan.sv ====
// Purpose: Decides per channel whether a changed ABCD value enters the queue
// Assumes: i_d_upd pulses once a channel's D bit has been written into its buffered input
// Notes: Keeps a copy of the output signaling buffer so change detection is local
`timescale 1ns/1ps
module sigstk_scan
  import sigstk_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_soft_rst,
  input wire logic i_d_upd,
  input wire logic [4:0] i_d_ch,
  input wire logic [3:0] i_abcd_in,
  input wire logic [NUM_CHANNELS-1:0] i_queue_enable_per_channel,
  input wire logic i_mf_end,
  sigstk_push_if.src push,
  output logic [4*NUM_CHANNELS-1:0] o_output_signaling_buffer,
  output logic o_mf_changed
);
  typedef struct packed {
    logic [4*NUM_CHANNELS-1:0] outbuf;
    logic changed;
    logic pend;
    logic valid;
    logic [4:0] ch;
    logic [3:0] abcd;
    logic mf_changed;
  } scan_t;
  scan_t s_r;
  scan_t s_nxt;

  // One channel evaluated per D-bit update; output buffer follows the input on change
  always_comb begin
    s_nxt = s_r;
    s_nxt.valid = 1'b0;
    s_nxt.mf_changed = 1'b0;
    if (i_d_upd) begin
      if (s_r.outbuf[i_d_ch*4 +: 4] != i_abcd_in) begin
        s_nxt.outbuf[i_d_ch*4 +: 4] = i_abcd_in;
        if (i_queue_enable_per_channel[i_d_ch]) begin
          s_nxt.valid = 1'b1;
          s_nxt.ch = i_d_ch;
          s_nxt.abcd = i_abcd_in;
          s_nxt.changed = 1'b1;
        end
      end
    end
    // Change seen this multiframe is reported at its end, then re-armed
    if (i_mf_end) begin
      s_nxt.mf_changed = s_r.changed | s_nxt.changed;
      s_nxt.changed = 1'b0;
    end
    if (i_soft_rst) begin
      s_nxt.changed = 1'b0;
      s_nxt.valid = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign push.valid = s_r.valid;
  assign push.channel = s_r.ch;
  assign push.abcd = s_r.abcd;
  assign o_output_signaling_buffer = s_r.outbuf;
  assign o_mf_changed = s_r.mf_changed;
endmodule

// ==== design/sigstk_queue.sv ====
// Purpose: Stores queued channel changes and serves them as two-word reads
// Assumes: Reads arrive as one-cycle strobes on the queue address
// Notes: Each channel holds at most one slot, so 32 entries can never overflow
`timescale 1ns/1ps
module sigstk_queue
  import sigstk_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_soft_rst,
  sigstk_push_if.dst push,
  input wire logic i_rd,
  output logic [7:0] o_word,
  output logic o_not_empty
);
  typedef struct packed {
    logic [PTR_W:0] wp;
    logic [PTR_W:0] rp;
    logic word_sel;
    logic [NUM_CHANNELS-1:0] queued;
  } q_t;
  q_t q_r;
  q_t q_nxt;
  logic [CH_W-1:0] ch_mem [QUEUE_DEPTH];
  logic [3:0] val_mem [QUEUE_DEPTH];
  logic empty;
  logic full;
  logic dup;
  logic last;
  logic pop;
  logic take;

  assign empty = (q_r.wp == q_r.rp);
  assign full = (q_r.wp[PTR_W] != q_r.rp[PTR_W]) && (q_r.wp[PTR_W-1:0] == q_r.rp[PTR_W-1:0]);
  // A channel whose entry leaves this cycle must queue its new change, or the change is lost
  assign pop = i_rd && !empty && q_r.word_sel;
  assign dup = q_r.queued[push.channel] && !(pop && (ch_mem[q_r.rp[PTR_W-1:0]] == push.channel));
  assign take = push.valid && !dup && (!full || pop);
  // Only the last word of the last entry clears the more flag
  assign last = (q_r.rp + (PTR_W+1)'(1)) == q_r.wp;
  assign push.full = full;
  assign o_not_empty = !empty;

  // Word 0 = channel with more set, word 1 = value; empty queue answers id 1, more 0
  always_comb begin
    if (empty) begin
      o_word = QUEUE_EMPTY_WORD;
    end else if (!q_r.word_sel) begin
      o_word = {1'b0, 1'b1, 1'b0, ch_mem[q_r.rp[PTR_W-1:0]]};
    end else begin
      o_word = {1'b1, !last, 2'b00, val_mem[q_r.rp[PTR_W-1:0]]};
    end
  end

  // A pending channel entry is refreshed in place rather than queued twice
  always_comb begin
    q_nxt = q_r;
    if (i_rd && !empty) begin
      q_nxt.word_sel = !q_r.word_sel;
      if (q_r.word_sel) begin
        q_nxt.rp = q_r.rp + (PTR_W+1)'(1);
        q_nxt.queued[ch_mem[q_r.rp[PTR_W-1:0]]] = 1'b0;
      end
    end
    if (take) begin
      q_nxt.wp = q_r.wp + (PTR_W+1)'(1);
      q_nxt.queued[push.channel] = 1'b1;
    end
    if (i_soft_rst) begin
      q_nxt = '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Storage has no reset; pointers alone say what is valid
  always_ff @(posedge i_clk) begin
    if (take) begin
      ch_mem[q_r.wp[PTR_W-1:0]] <= push.channel;
      val_mem[q_r.wp[PTR_W-1:0]] <= push.abcd;
    end
    if (push.valid && dup) begin
      for (int i = 0; i < QUEUE_DEPTH; i++) begin
        if (ch_mem[i] == push.channel) begin
          val_mem[i] <= push.abcd;
        end
      end
    end
  end
endmodule

// ==== design/sigstk_status.sv ====
// Purpose: Signaling change queue plus receive and transmit slip phase status for one framer
// Assumes: Slip pointers and frame strobes come from logic on i_clk
// Notes: Register port is byte wide; reads return combinationally, half bits straight from the inputs, the rest from registered state
// Contract
// - Only channels with queue enable set enter the change queue.
// - Change interrupt raised at multiframe end when an enabled channel changed.
// - Two reads return channel word first, then ABCD value word.
// - Framer software reset initialises queue read and write pointers.
// - Entry pushed only when buffered input ABCD differs from output ABCD.
// - Channels evaluated one at a time after D bit update.
// - Word 0: id 0 bit7, more 1 bit6, channel bits 4..0.
// - Word 1: id 1 bit7, more bit6, ABCD in bits 3..0.
// - Id 1 more 0 means stop; id 0 with more 0 never produced.
// - Queued ABCD value also present in output signaling buffer.
// - Receive delay: six bits in time slots, updated with receive frame irq.
// - Receive code steps 8 bits, 63 means 504 to 511 bits.
// - Receive bit 1 shows half supplying receive system bus.
// - Receive bit 0 shows half being filled from receiver.
// - Transmit delay: six bits in time slots, updated with transmit frame irq.
// - Transmit code steps 8 bits, 63 means 496 to 503 bits.
// - Transmit bit 1 shows half supplying transmitter.
// - Transmit bit 0 shows half filled from transmit system bus.
`timescale 1ns/1ps
module sigstk_status
  import sigstk_pkg::*;
#(
  parameter int PTR_BITS = 9
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_soft_rst,
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_d_upd,
  input wire logic [4:0] i_d_ch,
  input wire logic [3:0] i_abcd_in,
  input wire logic [NUM_CHANNELS-1:0] i_queue_enable_per_channel,
  input wire logic i_mf_end,
  output logic [4*NUM_CHANNELS-1:0] o_output_signaling_buffer,
  output logic o_signaling_change_irq,
  input wire logic i_rx_frame_irq,
  input wire logic [PTR_BITS-1:0] i_rx_line_ptr,
  input wire logic [PTR_BITS-1:0] i_rx_bus_ptr,
  input wire logic i_rx_half_to_bus,
  input wire logic i_rx_half_from_line,
  input wire logic i_tx_frame_irq,
  input wire logic [PTR_BITS-1:0] i_tx_bus_ptr,
  input wire logic [PTR_BITS-1:0] i_tx_line_ptr,
  input wire logic i_tx_half_to_line,
  input wire logic i_tx_half_from_bus,
  output logic o_queue_not_empty
);
  typedef struct packed {
    logic [DELAY_W-1:0] rx_slip_delay;
    logic [DELAY_W-1:0] tx_slip_delay;
    logic irq;
  } st_t;
  st_t st_r;
  st_t st_nxt;
  sigstk_push_if push_bus();
  logic mf_changed;
  logic [7:0] q_word;
  logic q_rd;

  // Bit delay to time-slot code: modulo buffer length, then drop the 3 in-slot bits
  function automatic logic [DELAY_W-1:0] slot_code(input logic [PTR_BITS-1:0] a,
                                                   input logic [PTR_BITS-1:0] b);
    logic [PTR_BITS-1:0] d;
    d = a - b;
    slot_code = d[DELAY_SHIFT +: DELAY_W];
  endfunction

  // Transmit buffer tops out one slot short, so its last step shares the all-ones code
  function automatic logic [DELAY_W-1:0] tx_code(input logic [DELAY_W-1:0] c);
    tx_code = (&c[DELAY_W-1:1]) ? {DELAY_W{1'b1}} : c;
  endfunction

  sigstk_scan u_scan (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_soft_rst(i_soft_rst),
    .i_d_upd(i_d_upd),
    .i_d_ch(i_d_ch),
    .i_abcd_in(i_abcd_in),
    .i_queue_enable_per_channel(i_queue_enable_per_channel),
    .i_mf_end(i_mf_end),
    .push(push_bus),
    .o_output_signaling_buffer(o_output_signaling_buffer),
    .o_mf_changed(mf_changed)
  );

  // A read of the queue address advances the two-word sequence
  assign q_rd = i_rd && (i_addr == ADDR_SIG_QUEUE);

  sigstk_queue u_queue (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_soft_rst(i_soft_rst),
    .push(push_bus),
    .i_rd(q_rd),
    .o_word(q_word),
    .o_not_empty(o_queue_not_empty)
  );

  // Delay snapshots taken once per frame so software sees a steady value
  always_comb begin
    st_nxt = st_r;
    if (i_rx_frame_irq) begin
      st_nxt.rx_slip_delay = slot_code(i_rx_line_ptr, i_rx_bus_ptr);
    end
    if (i_tx_frame_irq) begin
      st_nxt.tx_slip_delay = tx_code(slot_code(i_tx_bus_ptr, i_tx_line_ptr));
    end
    st_nxt.irq = mf_changed;
    if (i_soft_rst) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_signaling_change_irq = st_r.irq;

  // Read mux; unmapped addresses return zero
  always_comb begin
    unique case (i_addr)
      ADDR_SIG_QUEUE: o_rdata = q_word;
      ADDR_RX_PHASE: o_rdata = {st_r.rx_slip_delay, i_rx_half_to_bus, i_rx_half_from_line};
      ADDR_TX_PHASE: o_rdata = {st_r.tx_slip_delay, i_tx_half_to_line, i_tx_half_from_bus};
      default: o_rdata = PHASE_RESET;
    endcase
  end
endmodule

// ==== bench/sigstk_status_sva.sv ====
// Purpose: Port checks for the signaling queue and slip phase status block
// Assumes: One clock, asynchronous active-low reset
// Notes: Phase checks look at the read mux only; queue checks also use o_queue_not_empty
`timescale 1ns/1ps
module sigstk_status_sva
  import sigstk_pkg::*;
#(
  parameter int PTR_BITS = 9
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_soft_rst,
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_d_upd,
  input wire logic [4:0] i_d_ch,
  input wire logic [3:0] i_abcd_in,
  input wire logic [NUM_CHANNELS-1:0] i_queue_enable_per_channel,
  input wire logic i_mf_end,
  input wire logic [4*NUM_CHANNELS-1:0] o_output_signaling_buffer,
  input wire logic o_signaling_change_irq,
  input wire logic i_rx_half_to_bus,
  input wire logic i_rx_half_from_line,
  input wire logic i_tx_half_to_line,
  input wire logic i_tx_half_from_bus,
  input wire logic o_queue_not_empty
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  // Interrupt only ever follows a multiframe end by two cycles
  a_irq_needs_mf: assert property (o_signaling_change_irq |-> $past(i_mf_end, 2))
    else $error("change interrupt without multiframe end");
  // Empty queue reads as id 1 with more clear
  a_empty_word: assert property (!o_queue_not_empty && i_addr == ADDR_SIG_QUEUE |-> o_rdata == QUEUE_EMPTY_WORD)
    else $error("empty queue word wrong");
  a_word0_format: assert property (i_addr == ADDR_SIG_QUEUE && !o_rdata[7] |-> o_rdata[6:5] == 2'h2)
    else $error("channel word format wrong");
  // A taken channel word is followed by its value word
  a_word_alternates: assert property (i_rd && i_addr == ADDR_SIG_QUEUE && o_queue_not_empty && !o_rdata[7]
    |=> i_addr != ADDR_SIG_QUEUE || o_rdata[7])
    else $error("value word did not follow channel word");
  a_rx_halves: assert property (i_addr == ADDR_RX_PHASE |-> o_rdata[1:0] == {i_rx_half_to_bus, i_rx_half_from_line})
    else $error("rx half bits wrong");
  a_tx_halves: assert property (i_addr == ADDR_TX_PHASE |-> o_rdata[1:0] == {i_tx_half_to_line, i_tx_half_from_bus})
    else $error("tx half bits wrong");
  a_soft_clears: assert property (i_soft_rst [*2] |=> !o_queue_not_empty)
    else $error("soft reset left queue filled");
  // Pending read or soft reset could legally remove the entry, so both are excluded
  a_push_change: assert property ((i_d_upd && !i_soft_rst && !i_rd && i_queue_enable_per_channel[i_d_ch]
    && i_abcd_in != o_output_signaling_buffer[4*i_d_ch +: 4]) ##1 (!i_rd && !i_soft_rst)
    |-> ##[0:1] o_queue_not_empty)
    else $error("enabled change not queued");
endmodule
bind sigstk_status sigstk_status_sva #(.PTR_BITS(PTR_BITS)) sigstk_status_sva_inst (.i_clk, .i_arst_n, .i_soft_rst,
  .i_addr, .i_rd, .o_rdata, .i_d_upd, .i_d_ch, .i_abcd_in, .i_queue_enable_per_channel, .i_mf_end,
  .o_output_signaling_buffer, .o_signaling_change_irq, .i_rx_half_to_bus, .i_rx_half_from_line,
  .i_tx_half_to_line, .i_tx_half_from_bus, .o_queue_not_empty);

// ==== bench/sigstk_status_tb.sv ====
// Purpose: Directed bench for the signaling queue and slip phase status
// Assumes: Read data settles within the strobe cycle
// Notes: Channels 5 and 31 are queue enabled, channel 3 is not
`timescale 1ns/1ps
module sigstk_status_tb;
  import sigstk_pkg::*;
  logic i_clk = 0, i_arst_n = 0, i_soft_rst = 0, i_rd = 0, i_d_upd = 0, i_mf_end = 0;
  logic i_rx_frame_irq = 0, i_tx_frame_irq = 0, i_rx_half_to_bus = 0, i_rx_half_from_line = 0;
  logic i_tx_half_to_line = 0, i_tx_half_from_bus = 0, o_signaling_change_irq, o_queue_not_empty;
  logic [7:0] i_addr = 8'h00, o_rdata;
  logic [4:0] i_d_ch = 5'h00;
  logic [3:0] i_abcd_in = 4'h0;
  logic [NUM_CHANNELS-1:0] i_queue_enable_per_channel = 32'h8000_0020;
  logic [4*NUM_CHANNELS-1:0] o_output_signaling_buffer;
  logic [8:0] i_rx_line_ptr = 9'h000, i_rx_bus_ptr = 9'h000, i_tx_bus_ptr = 9'h000, i_tx_line_ptr = 9'h000;
  int n_errors = 0, num_checks = 0, n_irq = 0;

  sigstk_status #(.PTR_BITS(9)) sigstk_status_inst (.i_clk, .i_arst_n, .i_soft_rst, .i_addr, .i_rd, .o_rdata,
    .i_d_upd, .i_d_ch, .i_abcd_in, .i_queue_enable_per_channel, .i_mf_end, .o_output_signaling_buffer,
    .o_signaling_change_irq, .i_rx_frame_irq, .i_rx_line_ptr, .i_rx_bus_ptr, .i_rx_half_to_bus,
    .i_rx_half_from_line, .i_tx_frame_irq, .i_tx_bus_ptr, .i_tx_line_ptr, .i_tx_half_to_line,
    .i_tx_half_from_bus, .o_queue_not_empty);

  initial begin
    forever #12.5 i_clk = ~i_clk;
  end
  // Interrupt is a pulse, so count it at every edge
  always @(posedge i_clk) begin
    if (o_signaling_change_irq === 1'b1) n_irq++;
  end

  task automatic tick(input int n = 1);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask
  // Strobe is dropped for a cycle so back-to-back calls never redrive it
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_addr = a;
    i_rd = 1;
    #20 chk(o_rdata, e);
    tick();
    i_rd = 0;
    tick();
  endtask
  task automatic upd(input logic [4:0] c, input logic [3:0] v);
    i_d_ch = c;
    i_abcd_in = v;
    i_d_upd = 1;
    tick();
    i_d_upd = 0;
    tick(2);
  endtask
  task automatic mf(input int e);
    n_irq = 0;
    i_mf_end = 1;
    tick();
    i_mf_end = 0;
    tick(3);
    chk(8'(n_irq), 8'(e));
  endtask
  task automatic final_report();
    if (n_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    tick(16);
    i_arst_n = 1;
    tick();
    rd(ADDR_SIG_QUEUE, QUEUE_EMPTY_WORD);
    rd(8'hDD, 8'h00);
    upd(5'h03, 4'hA);
    mf(0);
    rd(ADDR_SIG_QUEUE, QUEUE_EMPTY_WORD);
    chk({4'h0, o_output_signaling_buffer[15:12]}, 8'h0A);
    upd(5'h05, 4'h9);
    upd(5'h1F, 4'h6);
    mf(1);
    rd(ADDR_SIG_QUEUE, 8'h45);
    rd(ADDR_SIG_QUEUE, 8'hC9);
    rd(ADDR_SIG_QUEUE, 8'h5F);
    rd(ADDR_SIG_QUEUE, 8'h86);
    rd(ADDR_SIG_QUEUE, QUEUE_EMPTY_WORD);
    chk({4'h0, o_output_signaling_buffer[23:20]}, 8'h09);
    upd(5'h05, 4'h9);
    mf(0);
    rd(ADDR_SIG_QUEUE, QUEUE_EMPTY_WORD);
    // Second change before the host reads refreshes the one pending entry
    upd(5'h05, 4'h2);
    upd(5'h05, 4'h4);
    rd(ADDR_SIG_QUEUE, 8'h45);
    rd(ADDR_SIG_QUEUE, 8'h84);
    upd(5'h05, 4'h3);
    i_soft_rst = 1;
    tick(2);
    i_soft_rst = 0;
    rd(ADDR_SIG_QUEUE, QUEUE_EMPTY_WORD);
    // Largest skews: 511 bits receive, 503 bits transmit
    {i_rx_line_ptr, i_rx_half_to_bus, i_rx_half_from_line} = {9'h1FF, 2'h2};
    {i_tx_bus_ptr, i_tx_half_to_line, i_tx_half_from_bus} = {9'h1F7, 2'h1};
    tick();
    rd(ADDR_RX_PHASE, 8'h02);
    rd(ADDR_TX_PHASE, 8'h01);
    i_rx_frame_irq = 1;
    i_tx_frame_irq = 1;
    tick();
    i_rx_frame_irq = 0;
    i_tx_frame_irq = 0;
    tick();
    rd(ADDR_RX_PHASE, 8'hFE);
    rd(ADDR_TX_PHASE, 8'hFD);
    {i_rx_half_to_bus, i_rx_half_from_line} = 2'h1;
    rd(ADDR_RX_PHASE, 8'hFD);
    final_report();
  end
  initial begin
    #(2000 * 25);
    n_errors++;
    final_report();
  end
endmodule
